/* bench/io_port_pin_control_props.sv */
// Concurrent checks on the port block's bus handshakes and pad outputs.
`timescale 1ns/1ps
module io_port_pin_control_props (
  input wire        CORE_CLK,
  input wire        RST,
  input wire        CLK_EN,
  input wire        STANDBY,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [1:0]  PORT_A_PIN_O,
  input wire [1:0]  PORT_A_PIN_OE,
  input wire [6:0]  PORT_B_PIN_OE,
  input wire [6:0]  PORT_B_PULLUP,
  input wire [6:0]  PORT_B_SLOW
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response changed before acceptance.");
  chk_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read data changed before acceptance.");
  chk_rdata_width: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("Read data has bits above the byte.");
  chk_write_answer: assert property (
    (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && CLK_EN) ##1 CLK_EN
    |=> S_AXI_BVALID) else $error("Write response late.");
  chk_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && CLK_EN |=> S_AXI_RVALID)
    else $error("Read data late.");
  chk_write_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("Write taken while response pending.");
  chk_read_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("Read taken while data pending.");
  chk_pull_float: assert property ((PORT_B_PULLUP & PORT_B_PIN_OE) == 7'h00)
    else $error("Pull-up on a driven pin.");
  chk_slow_drive: assert property ((PORT_B_SLOW & ~PORT_B_PIN_OE) == 7'h00)
    else $error("Slow edge on an undriven pin.");
  chk_standby_hold: assert property (
    STANDBY |=> $stable(PORT_A_PIN_O) && $stable(PORT_A_PIN_OE))
    else $error("First port pad moved in standby.");
endmodule // io_port_pin_control_props

bind io_port_pin_control io_port_pin_control_props u_props (
  .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .STANDBY(STANDBY),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PORT_A_PIN_O(PORT_A_PIN_O), .PORT_A_PIN_OE(PORT_A_PIN_OE), .PORT_B_PIN_OE(PORT_B_PIN_OE),
  .PORT_B_PULLUP(PORT_B_PULLUP), .PORT_B_SLOW(PORT_B_SLOW));

/* bench/io_port_pin_control_tb.sv */
// Self-checking bench for the port block: registers, pad decode, input reads and standby.
`timescale 1ns/1ps
`include "io_port_regs.vh"
module io_port_pin_control_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         clk_en = 1'b1;
  reg         standby = 1'b0;
  reg  [16:0] awaddr = 17'h0, araddr = 17'h0;
  reg  [31:0] wdata = 32'h0, rs = 32'hf7268a50;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [6:0]  per_b = 7'h0, ext_b = 7'h0, ext_b_en = 7'h0;
  reg  [1:0]  ext_a = 2'h0, ext_a_en = 2'h0;
  reg         per_a6 = 1'b0;
  reg  [6:0]  eoe, eo, epu, esl, lvl, msk, inv;
  reg  [7:0]  bl, bm;
  reg  [65:0] rq[$], bq[$];
  integer     bad_count = 0, checked = 0, cyc = 0, c, r;
  wire        awready, wready, bvalid, arready, rvalid, rx, ck_in, dt_in;
  wire [1:0]  bresp, rresp, pa_o, pa_oe, pa_pu, pa_sl, pa_pin;
  wire [31:0] rdata;
  wire [6:0]  pb_o, pb_oe, pb_pu, pb_sl, pb_pin;

  io_port_pin_control uut (
    .CORE_CLK(clk), .RST(rst), .CLK_EN(clk_en), .STANDBY(standby),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PORT_B_PIN_I(pb_pin), .PORT_B_PIN_O(pb_o), .PORT_B_PIN_OE(pb_oe),
    .PORT_B_PULLUP(pb_pu), .PORT_B_SLOW(pb_sl),
    .PORT_A_PIN_I(pa_pin), .PORT_A_PIN_O(pa_o), .PORT_A_PIN_OE(pa_oe),
    .PORT_A_PULLUP(pa_pu), .PORT_A_SLOW(pa_sl),
    .PWM_CHANNEL_ONE_A(per_b[0]), .PWM_CHANNEL_ONE_B(per_b[1]),
    .UART_UNIT_FOUR_TX(per_b[3]), .UART_UNIT_FOUR_RX(rx),
    .SINGLE_MASTER_I2C_UNIT1_CLK_OUT(per_b[4]), .SINGLE_MASTER_I2C_UNIT1_DATA_OUT(per_b[5]),
    .SINGLE_MASTER_I2C_UNIT1_AUX_OUT(per_b[6]), .SINGLE_MASTER_I2C_UNIT1_CLK_IN(ck_in),
    .SINGLE_MASTER_I2C_UNIT1_DATA_IN(dt_in), .SINGLE_MASTER_I2C_DATA_OUT(per_a6));

  pad_partner #(.W(7)) pads_b (.clk(clk), .drv_o(pb_o), .drv_oe(pb_oe), .pull_en(pb_pu),
    .ext_val(ext_b), .ext_en(ext_b_en), .pin(pb_pin));
  pad_partner #(.W(2)) pads_a (.clk(clk), .drv_o(pa_o), .drv_oe(pa_oe), .pull_en(pa_pu),
    .ext_val(ext_a), .ext_en(ext_a_en), .pin(pa_pin));

  initial
  begin
    forever #4 clk = ~clk;
  end

  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  function [14:0] ix(input integer k);
    case (k)
      0: ix = `PB_LATCH_IDX;
      1: ix = `PB_INPUT_IDX;
      2: ix = `PB_DIR_IDX;
      3: ix = `PB_FSEL_A_IDX;
      4: ix = `PB_FSEL_B_IDX;
      default: ix = 15'h7fcb;
    endcase
  endfunction

  // Pad controls {oe, o, pull-up, slow} for code {fsel A, fsel B, latch, dir}.
  function [3:0] pad(input [3:0] k, input hp, input p);
    case (k)
      4'h0, 4'h7, 4'hf: pad = 4'b0000;
      4'h2: pad = 4'b0010;
      4'h1, 4'h5, 4'h8: pad = 4'b1000;
      4'h3, 4'hb: pad = 4'b1100;
      4'h4, 4'hc: pad = 4'b1001;
      4'h6: pad = 4'b1101;
      4'h9: pad = {1'b1, p | ~hp, 2'b00};
      4'ha: pad = {1'b1, ~p & hp, 2'b00};
      4'he: pad = {1'b1, p | ~hp, 2'b01};
      default: pad = {hp & ~p, 3'b000};
    endcase
  endfunction

  task expect_port(input [3:0] k, input [6:0] hp, input [6:0] p, input [6:0] ev, input [6:0] ee);
    integer i;
    begin
      for (i = 0; i < 7; i = i + 1)
        {eoe[i], eo[i], epu[i], esl[i]} = pad(k, hp[i], p[i]);
      lvl = (eoe & eo) | (~eoe & ee & ev) | (~eoe & ~ee & epu);
      msk = eoe | ee | epu;
      inv = (k == 4'h7 || k == 4'ha) ? 7'h7f : 7'h00;
    end
  endtask

  // An entry is {response, expected data, mask of data bits that matter}.
  task cmp_val(input [65:0] e, input [33:0] g);
    begin
      checked = checked + 1;
      if ({g[33:32], g[31:0] & e[31:0]} !== {e[65:64], e[63:32] & e[31:0]})
      begin
        bad_count = bad_count + 1;
        $display("Error %0t got %h expected %h mask %h", $time, g, e[65:32], e[31:0]);
      end
    end
  endtask

  task cmp_pad(input [31:0] g, input [31:0] e, input [31:0] m);
    cmp_val({2'b00, e, m}, {2'b00, g});
  endtask

  task wr(input [14:0] a_ix, input [7:0] d, input [1:0] e);
    reg a;
    reg w;
    begin
      bq.push_back({e, 64'h0});
      awaddr <= {a_ix, 2'b00};
      wdata <= {{3{~d}}, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
        @(negedge clk);
        a = awvalid && awready;
        w = wvalid && wready;
        @(posedge clk);
        if (a)
          awvalid <= 1'b0;
        if (w)
          wvalid <= 1'b0;
      end
      while ((awvalid && !a) || (wvalid && !w));
      do @(negedge clk); while (!bvalid);
      @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
    end
  endtask

  task rd(input [14:0] a_ix, input [7:0] d, input [7:0] m, input [1:0] e);
    reg a;
    begin
      rq.push_back({e, 24'h0, d, 24'hffffff, m});
      araddr <= {a_ix, 2'b00};
      arvalid <= 1'b1;
      do
      begin
        @(negedge clk);
        a = arready;
        @(posedge clk);
      end
      while (!a);
      arvalid <= 1'b0;
      do @(negedge clk); while (!rvalid);
      @(posedge clk);
      rready <= 1'b1;
      @(posedge clk);
      rready <= 1'b0;
    end
  endtask

  task tally_and_finish;
    begin
      $display("Comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Results are sampled half a cycle before the edge that completes the handshake.
  always @(negedge clk)
  begin
    if (bvalid && bready)
      cmp_val(bq.pop_front(), {bresp, 32'h0});
    if (rvalid && rready)
      cmp_val(rq.pop_front(), {rresp, rdata});
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (c = 0; c < 6; c = c + 1)
      rd(ix(c), 8'h00, c == 1 ? 8'h80 : 8'hff, c == 5 ? `RESP_SLVERR : `RESP_OKAY);
    for (c = 0; c < 6; c = c + 1)
      if (c != 1)
      begin
        rs = xs(rs);
        wr(ix(c), rs[7:0], c == 5 ? `RESP_SLVERR : `RESP_OKAY);
        rd(ix(c), c == 5 ? 8'h00 : rs[7:0] & 8'h7f, 8'hff,
          c == 5 ? `RESP_SLVERR : `RESP_OKAY);
      end
    for (c = 0; c < 16; c = c + 1)
      for (r = 0; r < 2; r = r + 1)
      begin
        rs = xs(rs);
        per_b <= rs[6:0];
        per_a6 <= rs[7];
        ext_b <= rs[14:8];
        ext_b_en <= rs[22:16];
        ext_a <= rs[25:24];
        ext_a_en <= rs[27:26];
        wr(`PB_FSEL_A_IDX, {8{c[3]}}, `RESP_OKAY);
        wr(`PB_FSEL_B_IDX, {8{c[2]}}, `RESP_OKAY);
        wr(`PB_LATCH_IDX, {8{c[1]}}, `RESP_OKAY);
        wr(`PB_DIR_IDX, {8{c[0]}}, `RESP_OKAY);
        wr(`PA_HI_CTRL_IDX, {{2{c[2]}}, {2{c[3]}}, {2{c[0]}}, {2{c[1]}}}, `RESP_OKAY);
        repeat (4) @(posedge clk);
        @(negedge clk);
        expect_port(c[3:0], `PB_HAS_PERIPH, per_b, ext_b, ext_b_en);
        cmp_pad({pb_oe, pb_o & pb_oe, pb_pu, pb_sl},
          {eoe, eo, epu, esl}, 28'hfffffff);
        bl = {1'b0, lvl ^ inv};
        bm = {1'b1, msk};
        cmp_pad({rx, ck_in, dt_in}, {bl[2], bl[4], bl[5]},
          {bm[2], bm[4], bm[5]});
        expect_port(c[3:0], 7'h01, {6'h0, per_a6}, {5'h0, ext_a}, {5'h0, ext_a_en});
        cmp_pad({pa_oe, pa_o & pa_oe, pa_pu, pa_sl},
          {eoe[1:0], eo[1:0], epu[1:0], esl[1:0]}, 8'hff);
        @(posedge clk);
        rd(`PB_INPUT_IDX, bl, bm, `RESP_OKAY);
        rd(`PA_HI_INPUT_IDX, {6'h0, lvl[1:0] ^ inv[1:0]},
          {6'h3f, msk[1:0]}, `RESP_OKAY);
      end
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    wr(`PA_HI_CTRL_IDX, 8'h0f, `RESP_OKAY);
    repeat (2) @(posedge clk);
    standby <= 1'b1;
    wr(`PA_HI_CTRL_IDX, 8'h0c, `RESP_OKAY);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_pad({pa_oe, pa_o}, 4'hf, 4'hf);
    @(posedge clk);
    rd(`PA_HI_CTRL_IDX, 8'h0c, 8'hff, `RESP_OKAY);
    standby <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_pad({pa_oe, pa_o}, 4'hc, 4'hf);
    tally_and_finish;
  end
endmodule // io_port_pin_control_tb

/* bench/pad_partner.sv */
// Pad model for one port: works out each pin level from the block, a pull-up and the board.
`timescale 1ns/1ps
module pad_partner #(
  parameter W = 7
) (
  input  wire         clk,
  input  wire [W-1:0] drv_o,
  input  wire [W-1:0] drv_oe,
  input  wire [W-1:0] pull_en,
  input  wire [W-1:0] ext_val,
  input  wire [W-1:0] ext_en,
  output reg  [W-1:0] pin
);
  reg     [W-1:0] junk_q = {W{1'b0}};
  integer         i;

  // A pin nobody drives wanders every cycle, so the bench cannot lean on a settled unknown.
  always @(posedge clk)
    junk_q <= ~junk_q;

  // An open-drain pin that is released counts as undriven here.
  always @*
    for (i = 0; i < W; i = i + 1)
      pin[i] = drv_oe[i] ? drv_o[i] : ext_en[i] ? ext_val[i] :
               pull_en[i] ? 1'b1 : junk_q[i];
endmodule // pad_partner

/* hw/io_port_pin_control.v */
// Second port and first port bits 6 and 7: registers, pin decode, input read and standby hold of first port bits 6 and 7 only.
`timescale 1ns/1ps
`include "io_port_regs.vh"

module io_port_pin_control #(
  parameter ADDR_W = 17
) (
  input  wire                     CORE_CLK,
  input  wire                     RST,
  input  wire                     CLK_EN,
  input  wire                     STANDBY,
  input  wire [ADDR_W-1:0]        S_AXI_AWADDR,
  input  wire                     S_AXI_AWVALID,
  output wire                     S_AXI_AWREADY,
  input  wire [31:0]              S_AXI_WDATA,
  input  wire [3:0]               S_AXI_WSTRB,
  input  wire                     S_AXI_WVALID,
  output wire                     S_AXI_WREADY,
  output wire [1:0]               S_AXI_BRESP,
  output wire                     S_AXI_BVALID,
  input  wire                     S_AXI_BREADY,
  input  wire [ADDR_W-1:0]        S_AXI_ARADDR,
  input  wire                     S_AXI_ARVALID,
  output wire                     S_AXI_ARREADY,
  output wire [31:0]              S_AXI_RDATA,
  output wire [1:0]               S_AXI_RRESP,
  output wire                     S_AXI_RVALID,
  input  wire                     S_AXI_RREADY,
  input  wire [`PB_WIDTH-1:0]     PORT_B_PIN_I,
  output wire [`PB_WIDTH-1:0]     PORT_B_PIN_O,
  output wire [`PB_WIDTH-1:0]     PORT_B_PIN_OE,
  output wire [`PB_WIDTH-1:0]     PORT_B_PULLUP,
  output wire [`PB_WIDTH-1:0]     PORT_B_SLOW,
  input  wire [`PA_HI_WIDTH-1:0]  PORT_A_PIN_I,
  output wire [`PA_HI_WIDTH-1:0]  PORT_A_PIN_O,
  output wire [`PA_HI_WIDTH-1:0]  PORT_A_PIN_OE,
  output wire [`PA_HI_WIDTH-1:0]  PORT_A_PULLUP,
  output wire [`PA_HI_WIDTH-1:0]  PORT_A_SLOW,
  input  wire                     PWM_CHANNEL_ONE_A,
  input  wire                     PWM_CHANNEL_ONE_B,
  input  wire                     UART_UNIT_FOUR_TX,
  output wire                     UART_UNIT_FOUR_RX,
  input  wire                     SINGLE_MASTER_I2C_UNIT1_CLK_OUT,
  input  wire                     SINGLE_MASTER_I2C_UNIT1_DATA_OUT,
  input  wire                     SINGLE_MASTER_I2C_UNIT1_AUX_OUT,
  output wire                     SINGLE_MASTER_I2C_UNIT1_CLK_IN,
  output wire                     SINGLE_MASTER_I2C_UNIT1_DATA_IN,
  input  wire                     SINGLE_MASTER_I2C_DATA_OUT
);

  localparam IDX_W = ADDR_W - 2;

  function [2:0] reg_sel;
    input [IDX_W-1:0] idx;
    begin
      case (idx)
        `PB_LATCH_IDX:    reg_sel = `SEL_PB_LATCH;
        `PB_INPUT_IDX:    reg_sel = `SEL_PB_INPUT;
        `PB_DIR_IDX:      reg_sel = `SEL_PB_DIR;
        `PB_FSEL_A_IDX:   reg_sel = `SEL_PB_FSEL_A;
        `PB_FSEL_B_IDX:   reg_sel = `SEL_PB_FSEL_B;
        `PA_HI_CTRL_IDX:  reg_sel = `SEL_PA_CTRL;
        `PA_HI_INPUT_IDX: reg_sel = `SEL_PA_INPUT;
        default:          reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  reg  [`PB_WIDTH-1:0]    port_b_output_latch_q;
  reg  [`PB_WIDTH-1:0]    port_b_direction_q;
  reg  [`PB_WIDTH-1:0]    port_b_function_sel_a_q;
  reg  [`PB_WIDTH-1:0]    port_b_function_sel_b_q;
  reg  [7:0]              pa_ctrl_q;
  reg  [`PB_WIDTH-1:0]    b_meta_q;
  reg  [`PB_WIDTH-1:0]    b_sync_q;
  reg  [`PA_HI_WIDTH-1:0] a_meta_q;
  reg  [`PA_HI_WIDTH-1:0] a_sync_q;
  reg  [`PB_WIDTH-1:0]    b_o_q;
  reg  [`PB_WIDTH-1:0]    b_oe_q;
  reg  [`PB_WIDTH-1:0]    b_pu_q;
  reg  [`PB_WIDTH-1:0]    b_slow_q;
  reg  [`PA_HI_WIDTH-1:0] a_o_q;
  reg  [`PA_HI_WIDTH-1:0] a_oe_q;
  reg  [`PA_HI_WIDTH-1:0] a_pu_q;
  reg  [`PA_HI_WIDTH-1:0] a_slow_q;
  reg                     uart_rx_q;
  reg                     i2c_clk_in_q;
  reg                     i2c_data_in_q;
  reg                     aw_have_q;
  reg  [IDX_W-1:0]        aw_idx_q;
  reg                     w_have_q;
  reg  [7:0]              w_data_q;
  reg                     w_lane0_q;
  reg                     bvalid_q;
  reg  [1:0]              bresp_q;
  reg                     rvalid_q;
  reg  [31:0]             rdata_q;
  reg  [1:0]              rresp_q;

  wire [`PB_WIDTH-1:0]    b_en_d;
  wire [`PB_WIDTH-1:0]    b_val_d;
  wire [`PB_WIDTH-1:0]    b_pu_d;
  wire [`PB_WIDTH-1:0]    b_slow_d;
  wire [`PB_WIDTH-1:0]    b_inv;
  wire [`PB_WIDTH-1:0]    b_periph;
  wire [`PA_HI_WIDTH-1:0] a_en_d;
  wire [`PA_HI_WIDTH-1:0] a_val_d;
  wire [`PA_HI_WIDTH-1:0] a_pu_d;
  wire [`PA_HI_WIDTH-1:0] a_slow_d;
  wire [`PA_HI_WIDTH-1:0] a_inv;
  wire [`PB_WIDTH-1:0]    b_read;
  wire [`PA_HI_WIDTH-1:0] a_read;
  wire                    do_write;
  wire [2:0]              wr_sel;
  wire [2:0]              rd_sel;
  wire                    do_read;

  // Peripheral signals in pin order; pin 2 is the UART receive input and has no output.
  assign b_periph = {SINGLE_MASTER_I2C_UNIT1_AUX_OUT,
                     SINGLE_MASTER_I2C_UNIT1_DATA_OUT,
                     SINGLE_MASTER_I2C_UNIT1_CLK_OUT,
                     UART_UNIT_FOUR_TX,
                     1'b0,
                     PWM_CHANNEL_ONE_B,
                     PWM_CHANNEL_ONE_A};

  genvar gi;
  generate
    for (gi = 0; gi < `PB_WIDTH; gi = gi + 1)
    begin : g_port_b
      pin_mode_decode #(
        .HAS_PERIPH ((`PB_HAS_PERIPH >> gi) & 1)
      ) u_dec (
        .fsel_a    (port_b_function_sel_a_q[gi]),
        .fsel_b    (port_b_function_sel_b_q[gi]),
        .latch     (port_b_output_latch_q[gi]),
        .dir       (port_b_direction_q[gi]),
        .periph    (b_periph[gi]),
        .drive_en  (b_en_d[gi]),
        .drive_val (b_val_d[gi]),
        .pull_en   (b_pu_d[gi]),
        .slow_en   (b_slow_d[gi]),
        .read_inv  (b_inv[gi])
      );
    end
    for (gi = 0; gi < `PA_HI_WIDTH; gi = gi + 1)
    begin : g_port_a
      pin_mode_decode #(
        .HAS_PERIPH ((gi == 0) ? 1 : 0)
      ) u_dec (
        .fsel_a    (pa_ctrl_q[`PA_FSA_LSB + gi]),
        .fsel_b    (pa_ctrl_q[`PA_FSB_LSB + gi]),
        .latch     (pa_ctrl_q[`PA_LAT_LSB + gi]),
        .dir       (pa_ctrl_q[`PA_DIR_LSB + gi]),
        .periph    (SINGLE_MASTER_I2C_DATA_OUT),
        .drive_en  (a_en_d[gi]),
        .drive_val (a_val_d[gi]),
        .pull_en   (a_pu_d[gi]),
        .slow_en   (a_slow_d[gi]),
        .read_inv  (a_inv[gi])
      );
    end
  endgenerate

  // The read path always looks at the pin, whatever the direction.
  assign b_read = b_sync_q ^ b_inv;
  assign a_read = a_sync_q ^ a_inv;

  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_sel   = reg_sel(aw_idx_q);
  assign do_read  = S_AXI_ARVALID & ~rvalid_q;
  assign rd_sel   = reg_sel(S_AXI_ARADDR[ADDR_W-1:2]);

  assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_have_q & ~bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  assign PORT_B_PIN_O  = b_o_q;
  assign PORT_B_PIN_OE = b_oe_q;
  assign PORT_B_PULLUP = b_pu_q;
  assign PORT_B_SLOW   = b_slow_q;
  assign PORT_A_PIN_O  = a_o_q;
  assign PORT_A_PIN_OE = a_oe_q;
  assign PORT_A_PULLUP = a_pu_q;
  assign PORT_A_SLOW   = a_slow_q;

  assign UART_UNIT_FOUR_RX               = uart_rx_q;
  assign SINGLE_MASTER_I2C_UNIT1_CLK_IN  = i2c_clk_in_q;
  assign SINGLE_MASTER_I2C_UNIT1_DATA_IN = i2c_data_in_q;

  // Write channel: address and data are held separately and the write fires once both exist.
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_have_q               <= 1'b0;
      aw_idx_q                <= {IDX_W{1'b0}};
      w_have_q                <= 1'b0;
      w_data_q                <= 8'h00;
      w_lane0_q               <= 1'b0;
      bvalid_q                <= 1'b0;
      bresp_q                 <= `RESP_OKAY;
      port_b_output_latch_q   <= `PB_RESET;
      port_b_direction_q      <= `PB_RESET;
      port_b_function_sel_a_q <= `PB_RESET;
      port_b_function_sel_b_q <= `PB_RESET;
      pa_ctrl_q               <= `PA_CTRL_RESET;
    end
    else if (CLK_EN)
    begin
      if (S_AXI_AWVALID & S_AXI_AWREADY)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= S_AXI_AWADDR[ADDR_W-1:2];
      end
      if (S_AXI_WVALID & S_AXI_WREADY)
      begin
        w_have_q  <= 1'b1;
        w_data_q  <= S_AXI_WDATA[7:0];
        w_lane0_q <= S_AXI_WSTRB[0];
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        if (w_lane0_q)
        begin
          case (wr_sel)
            `SEL_PB_LATCH:  port_b_output_latch_q   <= w_data_q[`PB_WIDTH-1:0];
            `SEL_PB_DIR:    port_b_direction_q      <= w_data_q[`PB_WIDTH-1:0];
            `SEL_PB_FSEL_A: port_b_function_sel_a_q <= w_data_q[`PB_WIDTH-1:0];
            `SEL_PB_FSEL_B: port_b_function_sel_b_q <= w_data_q[`PB_WIDTH-1:0];
            `SEL_PA_CTRL:   pa_ctrl_q               <= w_data_q;
            default:        pa_ctrl_q               <= pa_ctrl_q;
          endcase
        end
      end
      else if (bvalid_q & S_AXI_BREADY)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address acceptance to data valid.
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `RESP_OKAY;
    end
    else if (CLK_EN)
    begin
      if (do_read)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= (rd_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        case (rd_sel)
          `SEL_PB_LATCH:  rdata_q <= {25'h0000000, port_b_output_latch_q};
          `SEL_PB_INPUT:  rdata_q <= {25'h0000000, b_read};
          `SEL_PB_DIR:    rdata_q <= {25'h0000000, port_b_direction_q};
          `SEL_PB_FSEL_A: rdata_q <= {25'h0000000, port_b_function_sel_a_q};
          `SEL_PB_FSEL_B: rdata_q <= {25'h0000000, port_b_function_sel_b_q};
          `SEL_PA_CTRL:   rdata_q <= {24'h000000, pa_ctrl_q};
          `SEL_PA_INPUT:  rdata_q <= {30'h00000000, a_read};
          default:        rdata_q <= 32'h00000000;
        endcase
      end
      else if (rvalid_q & S_AXI_RREADY)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Pin inputs arrive asynchronously and pass two flip-flops before any use.
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      b_meta_q      <= `PB_RESET;
      b_sync_q      <= `PB_RESET;
      a_meta_q      <= {`PA_HI_WIDTH{1'b0}};
      a_sync_q      <= {`PA_HI_WIDTH{1'b0}};
      uart_rx_q     <= 1'b0;
      i2c_clk_in_q  <= 1'b0;
      i2c_data_in_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      b_meta_q      <= PORT_B_PIN_I;
      b_sync_q      <= b_meta_q;
      a_meta_q      <= PORT_A_PIN_I;
      a_sync_q      <= a_meta_q;
      uart_rx_q     <= b_read[`PB_UART_RX_BIT];
      i2c_clk_in_q  <= b_read[`PB_I2C_CLK_BIT];
      i2c_data_in_q <= b_read[`PB_I2C_DATA_BIT];
    end
  end

  // Pad controls are registered so that the pads see no decode glitches.
  always @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      b_o_q    <= `PB_RESET;
      b_oe_q   <= `PB_RESET;
      b_pu_q   <= `PB_RESET;
      b_slow_q <= `PB_RESET;
      a_o_q    <= {`PA_HI_WIDTH{1'b0}};
      a_oe_q   <= {`PA_HI_WIDTH{1'b0}};
      a_pu_q   <= {`PA_HI_WIDTH{1'b0}};
      a_slow_q <= {`PA_HI_WIDTH{1'b0}};
    end
    else if (CLK_EN)
    begin
      b_o_q    <= b_val_d;
      b_oe_q   <= b_en_d;
      b_pu_q   <= b_pu_d;
      b_slow_q <= b_slow_d;
      // Freezing the pad registers also freezes peripheral data that is muxed onto the pin.
      if (~STANDBY)
      begin
        a_o_q    <= a_val_d;
        a_oe_q   <= a_en_d;
        a_pu_q   <= a_pu_d;
        a_slow_q <= a_slow_d;
      end
    end
  end

endmodule // io_port_pin_control

/* hw/io_port_regs.vh */
// Register indices, field layouts, reset values and decode codes for the I/O port block.
`ifndef IO_PORT_REGS_VH
`define IO_PORT_REGS_VH

// Register indices; the byte address is four times the index.
`define PB_LATCH_IDX      15'h7fcc
`define PB_INPUT_IDX      15'h7fcd
`define PB_DIR_IDX        15'h7fce
`define PB_FSEL_A_IDX     15'h7fcf
`define PB_FSEL_B_IDX     15'h7ffb
`define PA_HI_CTRL_IDX    15'h7fe0
`define PA_HI_INPUT_IDX   15'h7fe1

// Register selects produced by the address decoder.
`define SEL_NONE          3'h0
`define SEL_PB_LATCH      3'h1
`define SEL_PB_INPUT      3'h2
`define SEL_PB_DIR        3'h3
`define SEL_PB_FSEL_A     3'h4
`define SEL_PB_FSEL_B     3'h5
`define SEL_PA_CTRL       3'h6
`define SEL_PA_INPUT      3'h7

// Widths and reset values.
`define PB_WIDTH          7
`define PA_HI_WIDTH       2
`define PB_RESET          7'h00
`define PA_CTRL_RESET     8'h00
`define PB_HAS_PERIPH     7'h7b

// Field positions of the upper port A control register (bit 6 then bit 7 of each field).
`define PA_LAT_LSB        0
`define PA_DIR_LSB        2
`define PA_FSA_LSB        4
`define PA_FSB_LSB        6

// Port B bit positions of the multiplexed peripheral signals.
`define PB_UART_RX_BIT    2
`define PB_I2C_CLK_BIT    4
`define PB_I2C_DATA_BIT   5

// AXI responses.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// Pin decode codes, ordered function A, function B, latch, direction.
`define PM_OPEN           4'h0
`define PM_PULLUP         4'h2
`define PM_LOW            4'h1
`define PM_HIGH           4'h3
`define PM_LOW_SLOW       4'h4
`define PM_HIGH_SLOW      4'h6
`define PM_B_LOW          4'h5
`define PM_B_OPEN_INV     4'h7
`define PM_A_LOW          4'h8
`define PM_A_PER_INV      4'ha
`define PM_A_PER          4'h9
`define PM_A_HIGH         4'hb
`define PM_AB_LOW_SLOW    4'hc
`define PM_AB_PER_SLOW    4'he
`define PM_AB_PER_OD      4'hd
`define PM_AB_OPEN        4'hf

`endif

/* hw/pin_mode_decode.v */
// Combinational decode of one pin's function, latch and direction bits into pad controls.
`timescale 1ns/1ps
`include "io_port_regs.vh"

module pin_mode_decode #(
  parameter HAS_PERIPH = 1
) (
  input  wire fsel_a,
  input  wire fsel_b,
  input  wire latch,
  input  wire dir,
  input  wire periph,
  output reg  drive_en,
  output reg  drive_val,
  output reg  pull_en,
  output reg  slow_en,
  output reg  read_inv
);

  always @*
  begin
    drive_en  = 1'b0;
    drive_val = 1'b0;
    pull_en   = 1'b0;
    slow_en   = 1'b0;
    read_inv  = 1'b0;
    case ({fsel_a, fsel_b, latch, dir})
      `PM_OPEN: drive_en = 1'b0;
      `PM_PULLUP: pull_en = 1'b1;
      `PM_LOW: drive_en = 1'b1;
      `PM_HIGH:
      begin
        drive_en  = 1'b1;
        drive_val = 1'b1;
      end
      `PM_LOW_SLOW:
      begin
        drive_en = 1'b1;
        slow_en  = 1'b1;
      end
      `PM_HIGH_SLOW:
      begin
        drive_en  = 1'b1;
        drive_val = 1'b1;
        slow_en   = 1'b1;
      end
      `PM_B_LOW: drive_en = 1'b1;
      `PM_B_OPEN_INV: read_inv = 1'b1;
      `PM_A_LOW: drive_en = 1'b1;
      `PM_A_PER_INV:
      begin
        drive_en  = 1'b1;
        drive_val = (HAS_PERIPH != 0) ? ~periph : 1'b0;
        read_inv  = 1'b1;
      end
      `PM_A_PER:
      begin
        drive_en  = 1'b1;
        drive_val = (HAS_PERIPH != 0) ? periph : 1'b1;
      end
      `PM_A_HIGH:
      begin
        drive_en  = 1'b1;
        drive_val = 1'b1;
      end
      `PM_AB_LOW_SLOW:
      begin
        drive_en = 1'b1;
        slow_en  = 1'b1;
      end
      `PM_AB_PER_SLOW:
      begin
        drive_en  = 1'b1;
        drive_val = (HAS_PERIPH != 0) ? periph : 1'b1;
        slow_en   = 1'b1;
      end
      `PM_AB_PER_OD:
      begin
        // Open drain only ever pulls low; a high level is left to the external pull-up.
        drive_en = (HAS_PERIPH != 0) ? ~periph : 1'b0;
      end
      `PM_AB_OPEN: drive_en = 1'b0;
      default: drive_en = 1'b0;
    endcase
  end

endmodule // pin_mode_decode
